/* inc/bsp_pkg.sv */
/*
  Constants, register map and encodings for the bus service-request and
  polling controller. Assumes a 100 MHz core clock and a 32-bit Avalon-MM
  register bus with byte addresses.
*/
package bsp_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PP_SETTLE_NS  = 2000;
  localparam int PP_SETTLE_CYC = (PP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [3:0] REG_CMD_OFS  = 4'h0;
  localparam logic [3:0] REG_MASK_OFS = 4'h4;
  localparam logic [3:0] REG_STAT_OFS = 4'h8;
  localparam logic [3:0] REG_RES_OFS  = 4'hc;

  // Interrupt-enable mask
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam int         MASK_SRQ_BIT = 1;

  // Command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_GIVEN    = 3;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_CFG_LSB  = 9;
  localparam int CMD_BYTE_LSB = 16;
  localparam int CMD_ATN      = 24;

  // Status register fields
  localparam int ST_BUSY   = 0;
  localparam int ST_PEND   = 1;
  localparam int ST_SRQ    = 2;
  localparam int ST_ERR    = 3;
  localparam int ST_ROLE   = 4;
  localparam int ST_ARMED  = 5;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_SERIAL_POLL_REQUEST   = 3'h1,
    OP_PARALLEL_POLL_REQUEST   = 3'h2,
    OP_PPCFG   = 3'h3,
    OP_PPUNCFG = 3'h4,
    OP_SEND    = 3'h5
  } bsp_op_t;

  // Bus command bytes
  localparam logic [7:0] BC_PPC  = 8'h05;
  localparam logic [7:0] BC_PPU  = 8'h15;
  localparam logic [7:0] BC_SPE  = 8'h18;
  localparam logic [7:0] BC_SPD  = 8'h19;
  localparam logic [7:0] BC_LAG  = 8'h20;
  localparam logic [7:0] BC_UNL  = 8'h3f;
  localparam logic [7:0] BC_TAG  = 8'h40;
  localparam logic [7:0] BC_UNT  = 8'h5f;
  localparam logic [7:0] BC_PPE  = 8'h60;
  localparam logic [7:0] BC_PPD  = 8'h70;
  localparam logic [4:0] ADDR_MAX = 5'h1e;

  // Sequencer step kinds
  localparam logic [1:0] STEP_CMD   = 2'h0;
  localparam logic [1:0] STEP_READ  = 2'h1;
  localparam logic [1:0] STEP_END   = 2'h2;
  localparam logic [1:0] STEP_WRITE = 2'h3;

  typedef enum logic [3:0] {
    SQ_IDLE  = 4'h1,
    SQ_LOAD  = 4'h2,
    SQ_XFER  = 4'h4,
    SQ_PARALLEL_POLL_REQUEST = 4'h8
  } bsp_seq_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_WAIT = 4'h2,
    HS_HOLD = 4'h4,
    HS_DONE = 4'h8
  } bsp_hs_t;

endpackage

/* src/bsp_ctrl.sv */
/*
  Controller-side service-request sensing and bus polling engine.
  Holds the interrupt-enable mask, logs a service request once per arming,
  and runs serial poll, parallel poll, poll configure/unconfigure and single
  byte sends. Assumes synchronous bus inputs and an Avalon-MM master.

*/
// Design decision made here: the Avalon-MM register port.
// Summary of operation
// - Mask bit 1 enables service-request interrupt
// - Mask readback returns currently enabled mask
// - Request line sensed by level only
// - Logged request blocks interrupts until rearmed
// - Request still present at rearm refires
// - Serial poll returns one status byte
// - Serial poll needs a device address
// - Config low bits line, bit 3 sense
// - Configure one addressed device per command
// - Parallel poll returns wired eight-line byte
// - Unconfigure all, or only addressed device
// - Polls only while active controller
// - Attention true means command, else data
// - Address talker and listeners before data
`timescale 1ns/1ns
module bsp_ctrl
  import bsp_pkg::*;
#(
  parameter int SETTLE_CYC = PP_SETTLE_CYC
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ctrl_active_i,
  input  wire logic        srq_i,
  output logic             srq_irq_o,
  output logic             atn_o,
  output logic             eoi_o,
  input  wire logic [7:0]  dio_i,
  output logic [7:0]       dio_o,
  output logic [7:0]       dio_oe_n_o,
  input  wire logic        dav_i,
  output logic             dav_o,
  output logic             dav_oe_n_o,
  input  wire logic        nrfd_i,
  output logic             nrfd_o,
  output logic             nrfd_oe_n_o,
  input  wire logic        ndac_i,
  output logic             ndac_o,
  output logic             ndac_oe_n_o
);

  // Sequencer step: {kind, byte}
  function automatic logic [9:0] seq_step(input logic [2:0] op, input logic [2:0] idx,
                                          input logic given, input logic [4:0] addr,
                                          input logic [3:0] cfg, input logic [7:0] sbyte,
                                          input logic satn);
    logic [9:0] s;
    s = {STEP_END, 8'h00};
    case (op)
      OP_SERIAL_POLL_REQUEST:
      begin
        case (idx)
          3'h0:    s = {STEP_CMD, BC_UNL};
          3'h1:    s = {STEP_CMD, BC_SPE};
          3'h2:    s = {STEP_CMD, BC_TAG | {3'h0, addr}};
          3'h3:    s = {STEP_READ, 8'h00};
          3'h4:    s = {STEP_CMD, BC_SPD};
          3'h5:    s = {STEP_CMD, BC_UNT};
          default: s = {STEP_END, 8'h00};
        endcase
      end
      OP_PPCFG, OP_PPUNCFG:
      begin
        if (op == OP_PPUNCFG && !given)
          s = (idx == 3'h0) ? {STEP_CMD, BC_PPU} : {STEP_END, 8'h00};
        else
        begin
          case (idx)
            3'h0:    s = {STEP_CMD, BC_UNL};
            3'h1:    s = {STEP_CMD, BC_LAG | {3'h0, addr}};
            3'h2:    s = {STEP_CMD, BC_PPC};
            3'h3:    s = {STEP_CMD, (op == OP_PPCFG) ? (BC_PPE | {4'h0, cfg}) : BC_PPD};
            3'h4:    s = {STEP_CMD, BC_UNL};
            default: s = {STEP_END, 8'h00};
          endcase
        end
      end
      OP_SEND:
        s = (idx == 3'h0) ? {(satn ? STEP_CMD : STEP_WRITE), sbyte} : {STEP_END, 8'h00};
      default:
        s = {STEP_END, 8'h00};
    endcase
    return s;
  endfunction

  // Bus slave: one wait cycle, then answer
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        wr_acc;
  logic        mask_wr;
  logic        cmd_wr;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  assign wr_acc            = avs_write_i & ack_q;
  assign mask_wr           = wr_acc & (avs_address_i == REG_MASK_OFS);
  assign cmd_wr            = wr_acc & (avs_address_i == REG_CMD_OFS);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
  end

  // Interrupt-enable mask and request log
  logic [7:0] mask_q;
  logic       pend_q;
  logic       armed_q;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      mask_q <= MASK_RESET;
    else if (mask_wr && avs_byteenable_i[0])
      mask_q <= avs_writedata_i[7:0];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pend_q  <= 1'b0;
      armed_q <= 1'b1;
    end
    else if (mask_wr)
    begin
      // Missing low byte lane keeps the previous mask
      pend_q  <= 1'b0;
      armed_q <= 1'b1;
    end
    else if (armed_q && mask_q[MASK_SRQ_BIT] && srq_i)
    begin
      pend_q  <= 1'b1;
      armed_q <= 1'b0;
    end
  end

  assign srq_irq_o = pend_q;

  // Command intake
  bsp_seq_t   sq_q;
  logic [2:0] op_q;
  logic       given_q;
  logic [4:0] addr_q;
  logic [3:0] cfg_q;
  logic [7:0] sbyte_q;
  logic       satn_q;
  logic [2:0] idx_q;
  logic       err_q;
  logic [7:0] result_q;
  logic [7:0] cnt_q;
  logic       atn_q;
  logic       eoi_q;
  logic       hs_start;
  logic       hs_done;
  logic [7:0] hs_rdata;
  logic [2:0] w_op;
  logic       w_given;
  logic [4:0] w_addr;
  logic       bad;
  logic [9:0] step;

  assign w_op    = avs_writedata_i[CMD_OP_LSB +: 3];
  assign w_given = avs_writedata_i[CMD_GIVEN];
  assign w_addr  = avs_writedata_i[CMD_ADDR_LSB +: 5];

  always_comb
  begin
    bad = ~ctrl_active_i;
    case (w_op)
      OP_SERIAL_POLL_REQUEST:   bad = bad | ~w_given | (w_addr > ADDR_MAX);
      OP_PPCFG:   bad = bad | ~w_given | (w_addr > ADDR_MAX);
      OP_PPUNCFG: bad = bad | (w_given & (w_addr > ADDR_MAX));
      OP_PARALLEL_POLL_REQUEST,
      OP_SEND:    bad = bad;
      default:    bad = 1'b1;
    endcase
  end

  assign step     = seq_step(op_q, idx_q, given_q, addr_q, cfg_q, sbyte_q, satn_q);
  assign hs_start = (sq_q == SQ_LOAD) && (step[9:8] != STEP_END);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sq_q     <= SQ_IDLE;
      op_q     <= 3'h0;
      given_q  <= 1'b0;
      addr_q   <= 5'h00;
      cfg_q    <= 4'h0;
      sbyte_q  <= 8'h00;
      satn_q   <= 1'b0;
      idx_q    <= 3'h0;
      err_q    <= 1'b0;
      result_q <= 8'h00;
      cnt_q    <= 8'h00;
      atn_q    <= 1'b0;
      eoi_q    <= 1'b0;
    end
    else
    begin
      case (sq_q)
        SQ_IDLE:
        begin
          if (cmd_wr)
          begin
            err_q <= bad;
            if (!bad)
            begin
              op_q    <= w_op;
              given_q <= w_given;
              addr_q  <= w_addr;
              cfg_q   <= avs_writedata_i[CMD_CFG_LSB +: 4];
              sbyte_q <= avs_writedata_i[CMD_BYTE_LSB +: 8];
              satn_q  <= avs_writedata_i[CMD_ATN];
              idx_q   <= 3'h0;
              if (w_op == OP_PARALLEL_POLL_REQUEST)
              begin
                atn_q <= 1'b1;
                eoi_q <= 1'b1;
                cnt_q <= 8'(SETTLE_CYC);
                sq_q  <= SQ_PARALLEL_POLL_REQUEST;
              end
              else
                sq_q <= SQ_LOAD;
            end
          end
        end
        SQ_LOAD:
        begin
          // Addressing commands precede the status read
          atn_q <= (step[9:8] == STEP_CMD);
          if (step[9:8] == STEP_END)
          begin
            atn_q <= 1'b0;
            sq_q  <= SQ_IDLE;
          end
          else
            sq_q <= SQ_XFER;
        end
        SQ_XFER:
        begin
          if (hs_done)
          begin
            if (step[9:8] == STEP_READ)
              result_q <= hs_rdata;
            idx_q <= idx_q + 3'h1;
            sq_q  <= SQ_LOAD;
          end
        end
        SQ_PARALLEL_POLL_REQUEST:
        begin
          if (cnt_q == 8'h01)
          begin
            result_q <= dio_i;
            atn_q    <= 1'b0;
            eoi_q    <= 1'b0;
            sq_q     <= SQ_IDLE;
          end
          cnt_q <= cnt_q - 8'h01;
        end
        default:
          sq_q <= SQ_IDLE;
      endcase
    end
  end

  assign atn_o = atn_q;
  assign eoi_o = eoi_q;

  // Read data, captured in the wait cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else if (avs_read_i && !ack_q)
    begin
      case (avs_address_i)
        REG_MASK_OFS: rdata_q <= {24'h00_0000, mask_q};
        REG_RES_OFS:  rdata_q <= {24'h00_0000, result_q};
        REG_CMD_OFS,
        REG_STAT_OFS: rdata_q <= {26'h000_0000, armed_q, ctrl_active_i, err_q, srq_i, pend_q, sq_q != SQ_IDLE};
        default:      rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  bsp_handshake u_hs (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .start_i     (hs_start),
    .talk_i      (step[9:8] != STEP_READ),
    .wdata_i     (step[7:0]),
    .done_o      (hs_done),
    .rdata_o     (hs_rdata),
    .dio_i       (dio_i),
    .dio_o       (dio_o),
    .dio_oe_n_o  (dio_oe_n_o),
    .dav_i       (dav_i),
    .dav_o       (dav_o),
    .dav_oe_n_o  (dav_oe_n_o),
    .nrfd_i      (nrfd_i),
    .nrfd_o      (nrfd_o),
    .nrfd_oe_n_o (nrfd_oe_n_o),
    .ndac_i      (ndac_i),
    .ndac_o      (ndac_o),
    .ndac_oe_n_o (ndac_oe_n_o)
  );

  a_mask_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mask_wr && avs_byteenable_i[0] |=> mask_q == $past(avs_writedata_i[7:0]))
    else $error("mask not written");

  a_mask_view: assert property (@(posedge core_clk_i) disable iff (rst_i)
    avs_read_i && ack_q && avs_address_i == REG_MASK_OFS |-> avs_readdata_o == {24'h00_0000, mask_q})
    else $error("mask readback mismatch");

  a_irq_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(pend_q) |-> $past(srq_i) && $past(mask_q[MASK_SRQ_BIT]) && $past(armed_q))
    else $error("interrupt without sampled request");

  a_irq_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pend_q && !mask_wr |=> pend_q && !armed_q)
    else $error("logged interrupt lost before rearm");

  a_irq_refire: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mask_wr ##1 (mask_q[MASK_SRQ_BIT] && srq_i) |=> pend_q)
    else $error("request present at rearm not raised");

  a_serial_poll_request_addr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_wr && sq_q == SQ_IDLE && w_op == OP_SERIAL_POLL_REQUEST && !w_given |=> sq_q == SQ_IDLE && err_q)
    else $error("serial poll without address started");

  a_role_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_wr && sq_q == SQ_IDLE && !ctrl_active_i |=> sq_q == SQ_IDLE && err_q)
    else $error("poll started while not controller");

  a_cmd_atn: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sq_q == SQ_XFER |-> atn_q == (step[9:8] == STEP_CMD))
    else $error("attention does not match byte kind");

  a_parallel_poll_request_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(sq_q == SQ_PARALLEL_POLL_REQUEST) |-> (atn_q && eoi_q)[*4])
    else $error("parallel poll identify not held");

endmodule

/* src/bsp_handshake.sv */
/*
  One-byte three-wire handshake engine, as source (controller talks) or
  acceptor (controller listens). Bus lines are logical levels, 1 = true;
  an output enable low means this end pulls the line true.
*/
`timescale 1ns/1ns
module bsp_handshake
  import bsp_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       talk_i,
  input  wire logic [7:0] wdata_i,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  input  wire logic [7:0] dio_i,
  output logic [7:0]      dio_o,
  output logic [7:0]      dio_oe_n_o,
  input  wire logic       dav_i,
  output logic            dav_o,
  output logic            dav_oe_n_o,
  input  wire logic       nrfd_i,
  output logic            nrfd_o,
  output logic            nrfd_oe_n_o,
  input  wire logic       ndac_i,
  output logic            ndac_o,
  output logic            ndac_oe_n_o
);

  bsp_hs_t    st_q;
  logic       talk_q;
  logic [7:0] wdata_q;
  logic       dav_q;
  logic       nrfd_q;
  logic       ndac_q;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_q    <= HS_IDLE;
      talk_q  <= 1'b0;
      wdata_q <= 8'h00;
      dav_q   <= 1'b0;
      nrfd_q  <= 1'b0;
      ndac_q  <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      case (st_q)
        HS_IDLE:
        begin
          if (start_i)
          begin
            talk_q  <= talk_i;
            wdata_q <= wdata_i;
            nrfd_q  <= 1'b0;
            ndac_q  <= ~talk_i;
            st_q    <= HS_WAIT;
          end
        end
        HS_WAIT:
        begin
          // Source waits for all ready, acceptor for data valid
          if (talk_q && !nrfd_i)
          begin
            dav_q <= 1'b1;
            st_q  <= HS_HOLD;
          end
          else if (!talk_q && dav_i)
          begin
            rdata_o <= dio_i;
            nrfd_q  <= 1'b1;
            ndac_q  <= 1'b0;
            st_q    <= HS_HOLD;
          end
        end
        HS_HOLD:
        begin
          if (talk_q && !ndac_i)
          begin
            dav_q <= 1'b0;
            st_q  <= HS_DONE;
          end
          else if (!talk_q && !dav_i)
          begin
            nrfd_q <= 1'b0;
            st_q   <= HS_DONE;
          end
        end
        HS_DONE:
        begin
          talk_q <= 1'b0;
          st_q   <= HS_IDLE;
        end
        default:
          st_q <= HS_IDLE;
      endcase
    end
  end

  assign done_o      = (st_q == HS_DONE);
  assign dio_o       = wdata_q;
  assign dio_oe_n_o  = talk_q ? ~wdata_q : 8'hff;
  assign dav_o       = 1'b1;
  assign dav_oe_n_o  = ~dav_q;
  assign nrfd_o      = 1'b1;
  assign nrfd_oe_n_o = ~nrfd_q;
  assign ndac_o      = 1'b1;
  assign ndac_oe_n_o = ~ndac_q;

  a_dav_ready: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(dav_q) |-> $past(!nrfd_i) && talk_q)
    else $error("data valid raised before listeners ready");

endmodule

/* tb/bsp_instr_model.sv */
/*
  Behavioural instrument on the shared bus: one device at a fixed address
  that accepts commands and data, answers a serial poll and a parallel poll.
  Assumes logical line levels (1 = true) wired-OR with the controller.
*/
`timescale 1ns/1ns
module bsp_instr_model
  import bsp_pkg::*;
#(
  parameter logic [4:0] DEV_ADDR = 5'h07
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        slow_i,
  input  wire logic [7:0]  cond_i,
  input  wire logic        atn_i,
  input  wire logic        eoi_i,
  input  wire logic [7:0]  dio_i,
  input  wire logic        dav_i,
  input  wire logic        nrfd_i,
  input  wire logic        ndac_i,
  output logic             srq_o,
  output logic [7:0]       dio_o,
  output logic             dav_o,
  output logic             nrfd_o,
  output logic             ndac_o,
  output logic [31:0]      cmd_log_o,
  output logic [7:0]       data_o
);
  logic       listen_q, talk_q, spe_q, cfgp_q, ppon_q, sent_q, acc_q, srq_q;
  logic       go, acc_en, src_en, pp_on;
  logic [3:0] cfg_q;
  logic [1:0] dly_q, src_q;

  // Slow mode moves only every fourth cycle, except the source dropping data valid on ndac_i low
  always_ff @(posedge core_clk_i)
    dly_q <= rst_i ? 2'h0 : dly_q + 2'h1;

  assign go     = ~slow_i | (dly_q == 2'h3);
  assign acc_en = atn_i | (listen_q & ~talk_q);
  assign src_en = talk_q & spe_q & ~atn_i & ~sent_q;
  assign pp_on  = ppon_q & atn_i & eoi_i;
  assign nrfd_o = acc_en & acc_q;
  assign ndac_o = acc_en & ~acc_q;
  assign dav_o  = (src_q == 2'h2);
  assign srq_o  = srq_q;
  assign dio_o  = ((src_q != 2'h0) ? {cond_i[7], srq_q, cond_i[5:0]} : 8'h00)
                | ((pp_on & (cfg_q[3] ~^ srq_q)) ? 8'h01 << cfg_q[2:0] : 8'h00);

  // Acceptor and command decode
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      acc_q     <= 1'b0;
      listen_q  <= 1'b0;
      talk_q    <= 1'b0;
      spe_q     <= 1'b0;
      cfgp_q    <= 1'b0;
      ppon_q    <= 1'b0;
      cfg_q     <= 4'h0;
      cmd_log_o <= 32'h0;
      data_o    <= 8'h00;
    end
    else if (!acc_q && acc_en && dav_i && go)
    begin
      acc_q <= 1'b1;
      if (!atn_i)
        data_o <= dio_i;
      else
      begin
        cmd_log_o <= {cmd_log_o[23:0], dio_i};
        cfgp_q    <= (dio_i == BC_PPC) & listen_q;
        if (dio_i == BC_UNL)
          listen_q <= 1'b0;
        else if (dio_i == {3'h1, DEV_ADDR})
          listen_q <= 1'b1;
        if (dio_i == BC_UNT)
          talk_q <= 1'b0;
        else if (dio_i[7:5] == 3'h2)
          talk_q <= (dio_i[4:0] == DEV_ADDR);
        if (dio_i == BC_SPE)
          spe_q <= 1'b1;
        if (dio_i == BC_SPD)
          spe_q <= 1'b0;
        if (cfgp_q && dio_i[7:4] == 4'h6)
        begin
          cfg_q  <= dio_i[3:0];
          ppon_q <= 1'b1;
        end
        if ((cfgp_q && dio_i == BC_PPD) || dio_i == BC_PPU)
          ppon_q <= 1'b0;
      end
    end
    else if (acc_q && !dav_i && go)
      acc_q <= 1'b0;
  end

  // Status byte source and request line
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      src_q  <= 2'h0;
      sent_q <= 1'b0;
      srq_q  <= 1'b0;
    end
    else
    begin
      if (atn_i)
        sent_q <= 1'b0;
      if (req_i)
        srq_q <= 1'b1;
      case (src_q)
        2'h0: if (src_en && go) src_q <= 2'h1;
        2'h1: if (!nrfd_i && go) src_q <= 2'h2;
        default:
          if (!ndac_i)
          begin
            src_q  <= 2'h0;
            sent_q <= 1'b1;
            srq_q  <= 1'b0;
          end
      endcase
    end
  end
endmodule

/* tb/bus_service_request_poll_tb_top.sv */
/*
  Self-checking bench for the polling controller and one modelled instrument.
  Assumes wired-OR bus lines and a register bus master held until waitrequest low.
*/
`timescale 1ns/1ns
module bus_service_request_poll_tb_top
  import bsp_pkg::*;
();
  localparam logic [4:0] A  = 5'h07;
  localparam logic [7:0] TA = BC_TAG | {3'h0, A};
  localparam logic [7:0] LA = BC_LAG | {3'h0, A};
  logic        core_clk_i, rst_i, rd, wr, act, req, slow, wq, srq, irq, atn, eoi;
  logic        dav_oe, nrfd_oe, ndac_oe, ddav, dnrfd, dndac;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat, clog, q;
  logic [7:0]  doe, ddio, dat;
  wire logic [7:0] dio_w  = ~doe | ddio;
  wire logic       dav_w  = ~dav_oe | ddav;
  wire logic       nrfd_w = ~nrfd_oe | dnrfd;
  wire logic       ndac_w = ~ndac_oe | dndac;
  int          miscompares, check_count;

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  bsp_ctrl #(.SETTLE_CYC(4)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .ctrl_active_i(act), .srq_i(srq), .srq_irq_o(irq), .atn_o(atn), .eoi_o(eoi), .dio_i(dio_w),
    .dio_o(), .dio_oe_n_o(doe), .dav_i(dav_w), .dav_o(), .dav_oe_n_o(dav_oe), .nrfd_i(nrfd_w),
    .nrfd_o(), .nrfd_oe_n_o(nrfd_oe), .ndac_i(ndac_w), .ndac_o(), .ndac_oe_n_o(ndac_oe));

  bsp_instr_model #(.DEV_ADDR(A)) dev_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .slow_i(slow), .cond_i(8'h85),
    .atn_i(atn), .eoi_i(eoi), .dio_i(dio_w), .dav_i(dav_w), .nrfd_i(nrfd_w), .ndac_i(ndac_w),
    .srq_o(srq), .dio_o(ddio), .dav_o(ddav), .nrfd_o(dnrfd), .ndac_o(dndac), .cmd_log_o(clog),
    .data_o(dat));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
    int n;
    @(posedge core_clk_i);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    be  <= e;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (wq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      chk({31'h0, wq}, 32'h0);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask

  task automatic cmd(input logic [31:0] w);
    int n;
    bus(1'b1, REG_CMD_OFS, w, 4'hf);
    n = 0;
    do
    begin
      bus(1'b0, REG_STAT_OFS, 32'h0, 4'hf);
      n++;
    end
    while (q[ST_BUSY] !== 1'b0 && n < 500);
  endtask

  function automatic logic [31:0] cw(input bsp_op_t op, input logic g, input logic [4:0] a,
                                     input logic [3:0] c, input logic t, input logic [7:0] b);
    return {7'h0, t, b, 3'h0, c, a, g, op};
  endfunction

  task automatic raise();
    @(posedge core_clk_i);
    req <= 1'b1;
    @(posedge core_clk_i);
    req <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  task automatic irq_is(input logic e);
    // Pending follows a mask write by one cycle
    repeat (2) @(negedge core_clk_i);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic pp_chk(input logic [31:0] exp);
    cmd(cw(OP_PARALLEL_POLL_REQUEST, 1'b0, 5'h0, 4'h0, 1'b0, 8'h00));
    rdc(REG_RES_OFS, exp);
  endtask

  task automatic tally_and_finish();
    $display("TB: %0d checks, %0d miscompares", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    rst_i = 1'b1;
    rd    = 1'b0;
    wr    = 1'b0;
    act   = 1'b1;
    req   = 1'b0;
    slow  = 1'b0;
    adr   = 4'h0;
    be    = 4'hf;
    wd    = 32'h0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc(REG_MASK_OFS, 32'h0);
    rdc(REG_STAT_OFS, 32'h30);
    bus(1'b1, 4'h6, 32'hff, 4'hf);
    rdc(4'h6, 32'h0);
    rdc(REG_MASK_OFS, 32'h0);
    bus(1'b1, REG_MASK_OFS, 32'hfd, 4'hf);
    rdc(REG_MASK_OFS, 32'hfd);
    raise();
    irq_is(1'b0);
    rdc(REG_STAT_OFS, 32'h34);
    bus(1'b1, REG_MASK_OFS, 32'h02, 4'hf);
    irq_is(1'b1);
    rdc(REG_STAT_OFS, 32'h16);
    slow <= 1'b1;
    cmd(cw(OP_SERIAL_POLL_REQUEST, 1'b1, A, 4'h0, 1'b0, 8'h00));
    slow <= 1'b0;
    rdc(REG_RES_OFS, 32'hc5);
    chk(clog, {BC_SPE, TA, BC_SPD, BC_UNT});
    irq_is(1'b1);
    rdc(REG_STAT_OFS, 32'h12);
    bus(1'b1, REG_MASK_OFS, 32'h0, 4'h0);
    irq_is(1'b0);
    rdc(REG_MASK_OFS, 32'h02);
    bus(1'b1, REG_MASK_OFS, 32'hfd, 4'hf);
    raise();
    cmd(cw(OP_SERIAL_POLL_REQUEST, 1'b1, A, 4'h0, 1'b0, 8'h00));
    bus(1'b1, REG_MASK_OFS, 32'h02, 4'hf);
    irq_is(1'b0);
    cmd(cw(OP_SERIAL_POLL_REQUEST, 1'b0, A, 4'h0, 1'b0, 8'h00));
    rdc(REG_STAT_OFS, 32'h38);
    chk(clog, {BC_SPE, TA, BC_SPD, BC_UNT});
    act <= 1'b0;
    cmd(cw(OP_PPUNCFG, 1'b0, 5'h0, 4'h0, 1'b0, 8'h00));
    rdc(REG_STAT_OFS, 32'h28);
    chk(clog, {BC_SPE, TA, BC_SPD, BC_UNT});
    act <= 1'b1;
    cmd(cw(OP_PPCFG, 1'b1, A, 4'h4, 1'b0, 8'h00));
    chk(clog, {LA, BC_PPC, BC_PPE | 8'h04, BC_UNL});
    pp_chk(32'h10);
    raise();
    pp_chk(32'h00);
    cmd(cw(OP_PPCFG, 1'b1, A, 4'hb, 1'b0, 8'h00));
    pp_chk(32'h08);
    cmd(cw(OP_PPUNCFG, 1'b1, A, 4'h0, 1'b0, 8'h00));
    chk(clog, {LA, BC_PPC, BC_PPD, BC_UNL});
    pp_chk(32'h00);
    cmd(cw(OP_PPCFG, 1'b1, A, 4'hb, 1'b0, 8'h00));
    cmd(cw(OP_PPUNCFG, 1'b0, 5'h0, 4'h0, 1'b0, 8'h00));
    chk({24'h0, clog[7:0]}, {24'h0, BC_PPU});
    pp_chk(32'h00);
    cmd(cw(OP_SEND, 1'b0, 5'h0, 4'h0, 1'b1, LA));
    cmd(cw(OP_SEND, 1'b0, 5'h0, 4'h0, 1'b0, BC_UNL));
    chk({24'h0, dat}, {24'h0, BC_UNL});
    chk({24'h0, clog[7:0]}, {24'h0, LA});
    cmd(cw(OP_SEND, 1'b0, 5'h0, 4'h0, 1'b1, BC_UNL));
    cmd(cw(OP_SEND, 1'b0, 5'h0, 4'h0, 1'b0, 8'ha5));
    chk({24'h0, dat}, {24'h0, BC_UNL});
    tally_and_finish();
  end
endmodule
